/* File: hw/vtpd_pkg.sv */
package vtpd_pkg;

  // channel and line geometry
  localparam int unsigned NUM_CH = 16;
  localparam int unsigned NUM_LINES = 4;

  // register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_EQ0 = 8'h08;
  localparam logic [7:0] OFS_EQ1 = 8'h0C;
  localparam logic [7:0] OFS_EQ2 = 8'h10;
  localparam logic [7:0] OFS_ABS_BASE = 8'h40;
  localparam logic [7:0] OFS_REL_BASE = 8'h80;
  localparam logic [7:0] OFS_SLOT_BASE = 8'hC0;

  // coding format field values in the control word
  localparam logic [1:0] FMT_MULAW = 2'h0;
  localparam logic [1:0] FMT_ALAW = 2'h1;

  // values after reset
  localparam logic [14:0] GAIN_RESET = 15'h4000;
  localparam logic [15:0] EQ0_RESET = 16'h4000;
  localparam logic [15:0] EQ_TAP_RESET = 16'h0000;

  // fixed-point scaling
  localparam int unsigned GAIN_SHIFT = 14;
  localparam int unsigned EQ_SHIFT = 14;
  localparam int unsigned HP_SHIFT = 15;
  localparam logic [15:0] HP_POLE = 16'h6522;
  localparam int unsigned DEC_SCALE_SHIFT = 10;
  localparam logic [6:0] DEC_MID = 7'h20;

  // oversampled input framing counts
  localparam logic [5:0] DEC_LAST_IDX = 6'h3F;
  localparam logic [7:0] OS_HALF_LAST = 8'hFF;

  // pcm output framing counts
  localparam logic [9:0] PCM_CNT_MAX = 10'h3FF;
  localparam logic [9:0] PCM_COMP_BITS = 10'h080;
  localparam logic [9:0] PCM_LIN_BITS = 10'h100;
  localparam logic [7:0] ALAW_ZERO_CODE = 8'h7F;
  localparam logic [7:0] ALAW_TOGGLE = 8'h55;

  typedef enum logic [2:0] {PH_IDLE, PH_GAIN, PH_LP, PH_HP, PH_ENC} vtpd_phase_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } vtpd_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } vtpd_avs_rsp_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [1:0] fmt;
    logic [15:0] eq0;
    logic [15:0] eq1;
    logic [15:0] eq2;
    logic [15:0][14:0] absGain;
    logic [15:0][14:0] relGain;
    logic [15:0][3:0] slotMap;
    logic [8:0] osCnt;
    logic [15:0][6:0] acc;
    logic [15:0][15:0] dec;
    logic startPend;
    logic halfSel;
    vtpd_phase_t phase;
    logic [3:0] slot;
    logic procHalf;
    logic [15:0] work;
    logic [15:0][15:0] lpX1;
    logic [15:0][15:0] lpX2;
    logic [15:0][15:0] hpX1;
    logic [15:0][15:0] hpY1;
    logic [15:0][15:0] txWord;
    logic [7:0] frameCnt;
    logic pcmClkPrev;
    logic fsPrev;
    logic fsPend;
    logic [9:0] pcmCnt;
    logic pcmBit;
    logic pcmOe;
  } vtpd_state_t;

endpackage

/* File: hw/vtpd_core.sv */
`timescale 1ns/1ps
`default_nettype none

module vtpd_core
  import vtpd_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire vtpd_avs_req_t avsReq,
  output var vtpd_avs_rsp_t avsRsp,
  input wire logic osBitStrobe,
  input wire logic osFrameSync,
  input wire logic [3:0] oversampled_tx_lines,
  input wire logic pcmBitClk,
  input wire logic frame_sync_in,
  output logic pcm_tx_out,
  output logic pcmTxOe,
  output logic backplane_drive_enable_n,
  output logic backplaneDriveOe
);

  // clamp a wide signed value into the 16-bit sample range
  function automatic logic [15:0] sat16(input logic signed [33:0] v);
    if (v > 34'sd32767) begin
      sat16 = 16'h7FFF;
    end else if (v < -34'sd32768) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  // unsigned 15-bit gain in units of 4000 hex applied to a signed sample
  function automatic logic [15:0] applyGain(input logic [15:0] x, input logic [14:0] g);
    logic signed [33:0] p;
    p = (34'($signed(x)) * $signed({19'h00000, g})) >>> GAIN_SHIFT;
    applyGain = sat16(p);
  endfunction

  // segment compander, mu-law flavour
  function automatic logic [7:0] muEnc(input logic [15:0] x);
    logic [15:0] mag;
    logic [2:0] seg;
    logic [3:0] man;
    mag = x[15] ? 16'(-x) : x;
    mag = mag >> 2;
    if (mag > 16'd8158) begin
      mag = 16'd8158;
    end
    mag = mag + 16'd33;
    seg = 3'd7;
    for (int i = 6; i >= 0; i--) begin
      if (mag < (16'h0040 << i)) begin
        seg = 3'(i);
      end
    end
    man = 4'(mag >> ({1'b0, seg} + 4'h1));
    muEnc = ~{x[15], seg, man};
  endfunction

  // segment compander, A-law flavour with even-bit toggling
  function automatic logic [7:0] aEnc(input logic [15:0] x);
    logic [15:0] mag;
    logic [2:0] seg;
    logic [3:0] man;
    mag = x[15] ? ~x : x;
    mag = mag >> 3;
    seg = 3'd7;
    for (int i = 6; i >= 0; i--) begin
      if (mag < (16'h0020 << i)) begin
        seg = 3'(i);
      end
    end
    man = 4'(mag >> ((seg == 3'd0) ? 3'd1 : seg));
    aEnc = {~x[15], seg, man} ^ ALAW_TOGGLE;
    if (x == 16'h0000) begin
      aEnc = ALAW_ZERO_CODE;
    end
  endfunction

  vtpd_state_t s_q;
  vtpd_state_t s_d;

  // bus handshake: one wait state per access, data from the register
  assign avsRsp.waitrequest = (avsReq.read | avsReq.write) & ~s_q.ack;
  assign avsRsp.readdata = s_q.rdata;

  // pcm pins come from flops, one through an inverter, so they never glitch mid-bit
  assign pcm_tx_out = s_q.pcmBit;
  assign pcmTxOe = s_q.pcmOe;
  assign backplane_drive_enable_n = ~s_q.pcmOe;
  assign backplaneDriveOe = s_q.pcmOe;

  // all next-state logic
  always_comb begin
    logic busReq;
    logic [1:0] area;
    logic [3:0] idx;
    logic [3:0] ch;
    logic [6:0] cnt;
    logic [8:0] bitNo;
    logic [15:0] lpY;
    logic [15:0] hpY;
    logic [15:0] word;
    logic signed [33:0] tmp;
    logic fsRise;
    logic linear;
    logic active;
    logic [3:0] sIdx;
    busReq = avsReq.read | avsReq.write;
    area = avsReq.address[7:6];
    idx = avsReq.address[5:2];
    ch = 4'h0;
    cnt = 7'h00;
    bitNo = 9'h000;
    lpY = 16'h0000;
    hpY = 16'h0000;
    word = 16'h0000;
    tmp = 34'sd0;
    fsRise = frame_sync_in & ~s_q.fsPrev;
    linear = s_q.fmt[1];
    active = 1'b0;
    sIdx = 4'h0;
    s_d = s_q;

    // register slave: latch read data in the wait cycle, commit writes on the ack
    s_d.ack = busReq & ~s_q.ack;
    if (busReq && !s_q.ack) begin
      s_d.rdata = 32'h00000000;
      if (area == OFS_ABS_BASE[7:6]) begin
        s_d.rdata = {17'h00000, s_q.absGain[idx]};
      end else if (area == OFS_REL_BASE[7:6]) begin
        s_d.rdata = {17'h00000, s_q.relGain[idx]};
      end else if (area == OFS_SLOT_BASE[7:6]) begin
        s_d.rdata = {28'h0000000, s_q.slotMap[idx]};
      end else if (avsReq.address[7:2] == OFS_CTRL[7:2]) begin
        s_d.rdata = {30'h00000000, s_q.fmt};
      end else if (avsReq.address[7:2] == OFS_STATUS[7:2]) begin
        s_d.rdata = {23'h000000, s_q.frameCnt, s_q.phase != PH_IDLE};
      end else if (avsReq.address[7:2] == OFS_EQ0[7:2]) begin
        s_d.rdata = {16'h0000, s_q.eq0};
      end else if (avsReq.address[7:2] == OFS_EQ1[7:2]) begin
        s_d.rdata = {16'h0000, s_q.eq1};
      end else if (avsReq.address[7:2] == OFS_EQ2[7:2]) begin
        s_d.rdata = {16'h0000, s_q.eq2};
      end
    end
    if (avsReq.write && s_q.ack) begin
      if (area == OFS_ABS_BASE[7:6]) begin
        s_d.absGain[idx] = avsReq.writedata[14:0];
      end else if (area == OFS_REL_BASE[7:6]) begin
        s_d.relGain[idx] = avsReq.writedata[14:0];
      end else if (area == OFS_SLOT_BASE[7:6]) begin
        s_d.slotMap[idx] = avsReq.writedata[3:0];
      end else if (avsReq.address[7:2] == OFS_CTRL[7:2]) begin
        s_d.fmt = avsReq.writedata[1:0];
      end else if (avsReq.address[7:2] == OFS_EQ0[7:2]) begin
        s_d.eq0 = avsReq.writedata[15:0];
      end else if (avsReq.address[7:2] == OFS_EQ1[7:2]) begin
        s_d.eq1 = avsReq.writedata[15:0];
      end else if (avsReq.address[7:2] == OFS_EQ2[7:2]) begin
        s_d.eq2 = avsReq.writedata[15:0];
      end
    end

    // slot sequencer: one shared datapath walks all 16 slots per half frame
    unique case (s_q.phase)
      PH_IDLE: begin
        if (s_q.startPend) begin
          s_d.startPend = 1'b0;
          s_d.procHalf = s_q.halfSel;
          s_d.slot = 4'h0;
          s_d.phase = PH_GAIN;
        end
      end
      PH_GAIN: begin
        // relative gain is a pure level trim, so filter state is untouched
        ch = s_q.slotMap[s_q.slot];
        word = applyGain(s_q.dec[ch], s_q.absGain[ch]);
        s_d.work = applyGain(word, s_q.relGain[ch]);
        s_d.phase = PH_LP;
      end
      PH_LP: begin
        tmp = 34'($signed(s_q.work)) * 34'($signed(s_q.eq0));
        tmp = tmp + 34'($signed(s_q.lpX1[s_q.slot])) * 34'($signed(s_q.eq1));
        tmp = tmp + 34'($signed(s_q.lpX2[s_q.slot])) * 34'($signed(s_q.eq2));
        lpY = sat16(tmp >>> EQ_SHIFT);
        s_d.lpX2[s_q.slot] = s_q.lpX1[s_q.slot];
        s_d.lpX1[s_q.slot] = s_q.work;
        // only the odd 16 kHz sample goes on, which halves the rate
        if (s_q.procHalf) begin
          s_d.work = lpY;
          s_d.phase = PH_HP;
        end else if (s_q.slot == 4'hF) begin
          s_d.phase = PH_IDLE;
        end else begin
          s_d.slot = s_q.slot + 4'h1;
          s_d.phase = PH_GAIN;
        end
      end
      PH_HP: begin
        tmp = (34'($signed(HP_POLE)) * 34'($signed(s_q.hpY1[s_q.slot]))) >>> HP_SHIFT;
        tmp = tmp + 34'($signed(s_q.work)) - 34'($signed(s_q.hpX1[s_q.slot]));
        hpY = sat16(tmp);
        s_d.hpX1[s_q.slot] = s_q.work;
        s_d.hpY1[s_q.slot] = hpY;
        s_d.work = hpY;
        s_d.phase = PH_ENC;
      end
      PH_ENC: begin
        if (s_q.fmt == FMT_MULAW) begin
          s_d.txWord[s_q.slot] = {8'h00, muEnc(s_q.work)};
        end else if (s_q.fmt == FMT_ALAW) begin
          s_d.txWord[s_q.slot] = {8'h00, aEnc(s_q.work)};
        end else begin
          s_d.txWord[s_q.slot] = s_q.work;
        end
        if (s_q.slot == 4'hF) begin
          s_d.phase = PH_IDLE;
          s_d.frameCnt = s_q.frameCnt + 8'h01;
        end else begin
          s_d.slot = s_q.slot + 4'h1;
          s_d.phase = PH_GAIN;
        end
      end
    endcase

    // decimator: integrate-and-dump 64 one-bit samples per channel
    if (osBitStrobe) begin
      bitNo = osFrameSync ? 9'h000 : s_q.osCnt + 9'h001;
      s_d.osCnt = bitNo;
      for (int l = 0; l < NUM_LINES; l++) begin
        ch = 4'(l * 4) | {2'b00, bitNo[1:0]};
        cnt = s_q.acc[ch] + {6'h00, oversampled_tx_lines[l]};
        if (bitNo[7:2] == DEC_LAST_IDX) begin
          tmp = 34'($signed({1'b0, cnt}) - $signed({1'b0, DEC_MID}));
          s_d.dec[ch] = sat16(tmp <<< DEC_SCALE_SHIFT);
          s_d.acc[ch] = 7'h00;
        end else begin
          s_d.acc[ch] = cnt;
        end
      end
      // placed after the sequencer so a new start beats its clear
      if (bitNo[7:0] == OS_HALF_LAST) begin
        s_d.startPend = 1'b1;
        s_d.halfSel = bitNo[8];
      end
    end

    // pcm serialiser, advanced on rising edges of the sampled bit clock
    s_d.pcmClkPrev = pcmBitClk;
    s_d.fsPrev = frame_sync_in;
    if (fsRise) begin
      s_d.fsPend = 1'b1;
    end
    if (pcmBitClk && !s_q.pcmClkPrev) begin
      if (s_q.fsPend || fsRise) begin
        s_d.pcmCnt = 10'h000;
        s_d.fsPend = 1'b0;
      end else if (s_q.pcmCnt != PCM_CNT_MAX) begin
        s_d.pcmCnt = s_q.pcmCnt + 10'h001;
      end
      active = linear ? (s_d.pcmCnt < PCM_LIN_BITS) : (s_d.pcmCnt < PCM_COMP_BITS);
      sIdx = linear ? s_d.pcmCnt[7:4] : s_d.pcmCnt[6:3];
      word = s_q.txWord[sIdx];
      s_d.pcmOe = active;
      if (linear) begin
        s_d.pcmBit = active & word[~s_d.pcmCnt[3:0]];
      end else begin
        s_d.pcmBit = active & word[{1'b0, ~s_d.pcmCnt[2:0]}];
      end
    end
  end

  // single state register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.eq0 <= EQ0_RESET;
      s_q.eq1 <= EQ_TAP_RESET;
      s_q.eq2 <= EQ_TAP_RESET;
      s_q.pcmCnt <= PCM_CNT_MAX;
      s_q.phase <= PH_IDLE;
      for (int i = 0; i < NUM_CH; i++) begin
        s_q.absGain[i] <= GAIN_RESET;
        s_q.relGain[i] <= GAIN_RESET;
        s_q.slotMap[i] <= 4'(i);
      end
    end else begin
      s_q <= s_d;
    end
  end

endmodule // vtpd_core

`default_nettype wire

/* File: tb/vtpd_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module vtpd_chk
  import vtpd_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire vtpd_avs_req_t avsReq,
  input wire vtpd_avs_rsp_t avsRsp,
  input wire logic pcmBitClk,
  input wire logic frame_sync_in,
  input wire logic pcm_tx_out,
  input wire logic pcmTxOe,
  input wire logic backplane_drive_enable_n,
  input wire logic backplaneDriveOe
);
  logic rq;
  // one clock domain, so clocking and reset are given once
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  assign rq = avsReq.read | avsReq.write;
  property p_idle; !rq |-> !avsRsp.waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("wait with no request");
  property p_wait; rq && avsRsp.waitrequest |=> !avsRsp.waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait");
  // a hole in the map answers zero
  property p_unmap;
    avsReq.read && !avsRsp.waitrequest && avsReq.address == 8'h14 |-> avsRsp.readdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("hole read not zero");
  property p_en; backplane_drive_enable_n == !pcmTxOe; endproperty
  a_en: assert property (p_en) else $error("drive enable wrong");
  property p_eoe; backplaneDriveOe == pcmTxOe; endproperty
  a_eoe: assert property (p_eoe) else $error("enable pin float wrong");
  property p_float; !pcmTxOe |-> !pcm_tx_out; endproperty
  a_float: assert property (p_float) else $error("data while floating");
  // data may move only a few cycles after a bit clock rise, never after a fall
  property p_rise;
    $changed({pcmTxOe, pcm_tx_out}) |-> $past(pcmBitClk) && !$past(pcmBitClk, 2) ||
      $past(pcmBitClk, 2) && !$past(pcmBitClk, 3) || $past(pcmBitClk, 3) && !$past(pcmBitClk, 4);
  endproperty
  a_rise: assert property (p_rise) else $error("output off rising edge");
  property p_start; $rose(pcmTxOe) |-> frame_sync_in; endproperty
  a_start: assert property (p_start) else $error("drive not at frame start");
  c_wr: cover property (avsReq.write && !avsRsp.waitrequest);
  c_rd: cover property (avsReq.read && !avsRsp.waitrequest);
  c_drive: cover property ($rose(pcmTxOe));
endmodule // vtpd_chk
bind vtpd_core vtpd_chk i_vtpd_chk (
  .core_clk(core_clk), .resetn(resetn), .avsReq(avsReq), .avsRsp(avsRsp),
  .pcmBitClk(pcmBitClk), .frame_sync_in(frame_sync_in), .pcm_tx_out(pcm_tx_out),
  .pcmTxOe(pcmTxOe), .backplane_drive_enable_n(backplane_drive_enable_n),
  .backplaneDriveOe(backplaneDriveOe)
);
`default_nettype wire

/* File: tb/vtpd_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module vtpd_far_end
  import vtpd_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic full,
  input wire logic pcm_tx_out,
  input wire logic pcmTxOe,
  output logic osBitStrobe,
  output logic osFrameSync,
  output logic [3:0] oversampled_tx_lines,
  output logic pcmBitClk,
  output logic frame_sync_in,
  output logic [255:0] lastCap,
  output logic [9:0] lastCnt
);
  logic [4:0] osDiv;
  logic [8:0] osIdx;
  logic [2:0] bDiv;
  logic [8:0] pIdx;
  logic [255:0] cap;
  logic [9:0] cnt;
  // a strobe each 24 cycles, four channels interleaved on every line
  assign osBitStrobe = osDiv == 5'h00;
  assign osFrameSync = osBitStrobe && osIdx == 9'h000;
  // half ones per sample decimates to zero, all ones is full scale
  assign oversampled_tx_lines = full ? 4'hF : {4{osIdx[2]}};
  // six-cycle bit clock; sync spans bit 0 so the rise precedes it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      {osDiv, osIdx, bDiv, pcmBitClk, frame_sync_in, cap, cnt, lastCap, lastCnt} <= '0;
      pIdx <= 9'h1FE;
    end else begin
      osDiv <= (osDiv == 5'h17) ? 5'h00 : osDiv + 5'h01;
      osIdx <= osIdx + {8'h00, osBitStrobe};
      bDiv <= (bDiv == 3'h5) ? 3'h0 : bDiv + 3'h1;
      if (bDiv == 3'h5) begin
        pcmBitClk <= 1'b1;
        pIdx <= pIdx + 9'h001;
      end
      if (bDiv == 3'h2) begin
        pcmBitClk <= 1'b0;
      end
      // sample late in the bit, long after the launching rise
      if (bDiv == 3'h4 && pcmTxOe) begin
        cnt <= cnt + 10'h001;
        cap[8'hFF - pIdx[7:0]] <= pIdx[8] ? cap[8'hFF - pIdx[7:0]] : pcm_tx_out;
      end
      if (bDiv == 3'h4) begin
        frame_sync_in <= pIdx == 9'h1FF;
      end
      if (bDiv == 3'h4 && pIdx == 9'h1FF) begin
        lastCap <= cap;
        lastCnt <= cnt;
        cap <= '0;
        cnt <= 10'h000;
      end
    end
  end
endmodule // vtpd_far_end
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vtpd_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic full = 1'b1;
  vtpd_avs_req_t avsReq = '0;
  vtpd_avs_rsp_t avsRsp;
  logic osBitStrobe, osFrameSync, pcmBitClk, frame_sync_in;
  logic pcm_tx_out, pcmTxOe, driveEnN, driveOe;
  logic [3:0] osLines;
  logic [255:0] lastCap;
  logic [9:0] lastCnt;
  logic [31:0] q;
  int num_errors = 0;
  int tests_run = 0;
  always #5 core_clk = ~core_clk;
  vtpd_core i_vtpd_core (
    .core_clk(core_clk), .resetn(resetn), .avsReq(avsReq), .avsRsp(avsRsp),
    .osBitStrobe(osBitStrobe), .osFrameSync(osFrameSync), .oversampled_tx_lines(osLines),
    .pcmBitClk(pcmBitClk), .frame_sync_in(frame_sync_in), .pcm_tx_out(pcm_tx_out),
    .pcmTxOe(pcmTxOe), .backplane_drive_enable_n(driveEnN), .backplaneDriveOe(driveOe)
  );
  vtpd_far_end i_vtpd_far_end (
    .core_clk(core_clk), .resetn(resetn), .full(full), .pcm_tx_out(pcm_tx_out),
    .pcmTxOe(pcmTxOe), .osBitStrobe(osBitStrobe), .osFrameSync(osFrameSync),
    .oversampled_tx_lines(osLines), .pcmBitClk(pcmBitClk), .frame_sync_in(frame_sync_in),
    .lastCap(lastCap), .lastCnt(lastCnt)
  );
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // hold the request until waitrequest is sampled low, then release
  task automatic bus(input logic isWr, input logic [7:0] a, input logic [31:0] d);
    int i;
    avsReq <= '{read: !isWr, write: isWr, address: a, writedata: d};
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (avsRsp.waitrequest === 1'b0) break;
    end
    q = avsRsp.readdata;
    if (i == 20) begin
      num_errors++;
      wrap_up();
    end
    avsReq <= '0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(n, q, exp);
  endtask
  // count frame sync rises; the far end latches each frame at the rise
  task automatic wait_fs(input int n);
    int i;
    for (int k = 0; k < n; k++) begin
      for (i = 0; i < 4000 && frame_sync_in !== 1'b0; i++) @(posedge core_clk);
      for (i = 0; i < 4000 && frame_sync_in !== 1'b1; i++) @(posedge core_clk);
      if (i == 4000) begin
        num_errors++;
        wrap_up();
      end
    end
  endtask
  task automatic t_regs();
    rd_chk("ctrl", OFS_CTRL, 32'h0);
    rd_chk("abs0", OFS_ABS_BASE, 32'h4000);
    rd_chk("rel15", OFS_REL_BASE + 8'h3C, 32'h4000);
    rd_chk("slot5", OFS_SLOT_BASE + 8'h14, 32'h5);
    rd_chk("eq0", OFS_EQ0, 32'h4000);
    rd_chk("eq1", OFS_EQ1, 32'h0);
    rd_chk("eq2", OFS_EQ2, 32'h0);
    rd_chk("status", OFS_STATUS, 32'h0);
    wr(OFS_ABS_BASE + 8'h0C, 32'hFFFFFFFF);
    rd_chk("abs3", OFS_ABS_BASE + 8'h0C, 32'h7FFF);
    wr(OFS_ABS_BASE + 8'h0C, 32'h34ED);
    rd_chk("abs3", OFS_ABS_BASE + 8'h0C, 32'h34ED);
    wr(OFS_REL_BASE + 8'h0C, 32'h0);
    wr(8'h14, 32'h1234);
    rd_chk("hole", 8'h14, 32'h0);
    $display("test regs done");
  endtask
  // full-scale input; channel 3 muted by relative gain, the rest by absolute
  task automatic t_mute();
    for (int c = 0; c < 16; c++) begin
      if (c != 3) wr(OFS_ABS_BASE + 8'(4 * c), 32'h0);
    end
    wr(OFS_CTRL, {30'h0, FMT_ALAW});
    wait_fs(5);
    check("bits", {22'h0, lastCnt}, 32'h80);
    for (int s = 0; s < 16; s++) begin
      check("alaw", {24'h0, lastCap[255 - 8 * s -: 8]}, 32'h7F);
    end
    $display("test mute done");
  endtask
  // every coding format; a format change takes a whole frame to show
  task automatic t_fmts();
    logic [1:0] f [4] = '{FMT_MULAW, 2'h2, 2'h3, FMT_ALAW};
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, {30'h0, f[i]});
      wait_fs(2);
      check("bits", {22'h0, lastCnt}, f[i][1] ? 32'h100 : 32'h80);
      if (f[i][1]) check("linear", {31'h0, |lastCap}, 32'h0);
    end
    $display("test formats done");
  endtask
  // unmute channel 0, then steer it into slot 1 as well
  task automatic t_gain();
    wr(OFS_ABS_BASE, 32'h4000);
    wait_fs(5);
    check("slot0", {31'h0, lastCap[255 -: 8] != 8'h7F}, 32'h1);
    check("slot1", {24'h0, lastCap[247 -: 8]}, 32'h7F);
    wr(OFS_SLOT_BASE + 8'h04, 32'h0);
    wait_fs(5);
    check("slot1", {31'h0, lastCap[247 -: 8] != 8'h7F}, 32'h1);
    check("slot2", {24'h0, lastCap[239 -: 8]}, 32'h7F);
    $display("test gain done");
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_mute();
    t_fmts();
    t_gain();
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
